// *** larb_pkg.sv ***
/*
 * Constants shared by the loop alarm register bank: register addresses,
 * reset values, alarm mode bit positions, interrupt bits and the enums.
 * Assumes a 16-bit register port that addresses each register by its index.
 */
package larb_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;

    localparam logic [15:0] A_UPPER    = 16'h0064;
    localparam logic [15:0] A_LOWER    = 16'h0065;
    localparam logic [15:0] A_TYPE     = 16'h0066;
    localparam logic [15:0] A_MODE     = 16'h0067;
    localparam logic [15:0] A_OUTSEL   = 16'h0068;
    localparam logic [15:0] A_HIGH     = 16'h0069;
    localparam logic [15:0] A_LOW      = 16'h006A;
    localparam logic [15:0] A_HYST     = 16'h006B;
    localparam logic [15:0] A_TARGET   = 16'h006C;
    localparam logic [15:0] A_MEAS     = 16'h006D;
    localparam logic [15:0] A_PCT      = 16'h006E;
    localparam logic [15:0] A_IRQ_STAT = 16'h0080;
    localparam logic [15:0] A_IRQ_MASK = 16'h0081;
    localparam logic [15:0] A_CTRL     = 16'h0082;

    localparam logic [15:0] RST_UPPER = 16'h7FFF;
    localparam logic [15:0] RST_LOWER = 16'h8000;
    localparam logic [15:0] RST_ZERO  = 16'h0000;

    localparam logic [15:0] TYPE_MAX = 16'h0006;
    localparam logic [15:0] PCT_MAX  = 16'h2710;
    localparam logic [15:0] PCT_MIN  = 16'hD8F0;

    localparam int MODE_LATCH    = 1;
    localparam int MODE_POL      = 2;
    localparam int MODE_AUDIBLE  = 5;
    localparam int MODE_SHUTDOWN = 6;

    localparam int CTRL_ACK = 0;

    localparam int IRQ_W      = 2;
    localparam int IRQ_ALARM  = 0;
    localparam int IRQ_REJECT = 1;

    localparam int EVENT_W_MAX = 15;

    typedef enum logic [2:0] {
        AT_OFF   = 3'h0,
        AT_PHI   = 3'h1,
        AT_PLO   = 3'h2,
        AT_PBOTH = 3'h3,
        AT_DHI   = 3'h4,
        AT_DLO   = 3'h5,
        AT_DBOTH = 3'h6
    } larb_atype_e;

    typedef enum logic [1:0] {
        ST_CLEAR  = 2'h0,
        ST_ACTIVE = 2'h1,
        ST_HELD   = 2'h3
    } larb_state_e;

endpackage

// *** larb_sync.sv ***
/*
 * Two flip-flop synchroniser for one pin level.
 * Assumes the pin is asynchronous to clk_i; only the second stage is read.
 */
`timescale 1ns/1ps
module larb_sync #(
    parameter bit RST_VAL = 1'b1
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    output logic      q_o
);

    logic meta;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= RST_VAL;
            q_o  <= RST_VAL;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule

// *** larb_alarm.sv ***
/*
 * Loop alarm evaluator: threshold compare with hysteresis, self clearing
 * or latching alarm state.
 * Assumes all inputs come from logic on clk_i.
 */
`timescale 1ns/1ps
module larb_alarm (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] pv_i,
    input  wire logic [15:0] sp_i,
    input  wire logic [2:0]  type_i,
    input  wire logic [15:0] hi_i,
    input  wire logic [15:0] lo_i,
    input  wire logic [15:0] hys_i,
    input  wire logic        latch_i,
    input  wire logic        ack_i,
    output logic             active_o,
    output logic             rise_o
);

    larb_pkg::larb_state_e  state;
    larb_pkg::larb_state_e  next_state;
    larb_pkg::larb_atype_e  atype;
    logic signed [17:0]     x;
    logic signed [17:0]     hi;
    logic signed [17:0]     lo;
    logic signed [17:0]     hys;
    logic                   cond_hi;
    logic                   cond_lo;
    logic                   use_hi;
    logic                   use_lo;
    logic                   cond;

    assign atype = larb_pkg::larb_atype_e'(type_i);
    assign hi    = 18'($signed(hi_i));
    assign lo    = 18'($signed(lo_i));
    assign hys   = 18'($signed(hys_i));

    // Deviation types compare the distance from the setpoint, which needs
    // one extra bit so a full-range difference cannot wrap; x carries two.
    always_comb begin
        use_hi = 1'b0;
        use_lo = 1'b0;
        x      = 18'($signed(pv_i));
        case (atype)
            larb_pkg::AT_PHI:   use_hi = 1'b1;
            larb_pkg::AT_PLO:   use_lo = 1'b1;
            larb_pkg::AT_PBOTH: begin
                use_hi = 1'b1;
                use_lo = 1'b1;
            end
            larb_pkg::AT_DHI: begin
                use_hi = 1'b1;
                x      = 18'($signed(pv_i)) - 18'($signed(sp_i));
            end
            larb_pkg::AT_DLO: begin
                use_lo = 1'b1;
                x      = 18'($signed(pv_i)) - 18'($signed(sp_i));
            end
            larb_pkg::AT_DBOTH: begin
                use_hi = 1'b1;
                use_lo = 1'b1;
                x      = 18'($signed(pv_i)) - 18'($signed(sp_i));
            end
            default: x = 18'($signed(pv_i));
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cond_hi <= 1'b0;
            cond_lo <= 1'b0;
        end else begin
            cond_hi <= cond_hi ? (x > hi - hys) : (x > hi);
            cond_lo <= cond_lo ? (x < lo + hys) : (x < lo);
        end
    end

    assign cond = (use_hi & cond_hi) | (use_lo & cond_lo);

    always_comb begin
        next_state = state;
        case (state)
            larb_pkg::ST_CLEAR:
                if (cond) next_state = larb_pkg::ST_ACTIVE;
            larb_pkg::ST_ACTIVE:
                if (!cond) next_state = latch_i ? larb_pkg::ST_HELD : larb_pkg::ST_CLEAR;
            larb_pkg::ST_HELD:
                if (cond) next_state = larb_pkg::ST_ACTIVE;
                else if (ack_i || !latch_i) next_state = larb_pkg::ST_CLEAR;
            default: next_state = larb_pkg::ST_CLEAR;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) state <= larb_pkg::ST_CLEAR;
        else       state <= next_state;
    end

    assign active_o = (state != larb_pkg::ST_CLEAR);
    assign rise_o   = (state == larb_pkg::ST_CLEAR) && cond;

    a_latch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        state == larb_pkg::ST_ACTIVE && latch_i && !cond |=> state == larb_pkg::ST_HELD)
        else $error("latched alarm did not hold");

endmodule

// *** larb_top.sv ***
/*
 * Loop four alarm parameter bank and loop five setpoint and readback.
 * Assumes a one-clock register port with read data one cycle after the
 * read strobe, process values from control logic on clk_i, and an
 * active-low silence pushbutton pin.
 */
`timescale 1ns/1ps
module larb_top #(
    parameter int EVENT_W = 15
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic [15:0]        addr_i,
    input  wire logic [15:0]        wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    input  wire logic [15:0]        loop4_pv_i,
    input  wire logic [15:0]        loop4_sp_i,
    input  wire logic [15:0]        loop5_pv_i,
    input  wire logic [15:0]        loop5_out_i,
    input  wire logic               silence_n_i,
    output logic [15:0]             rdata_o,
    output logic [15:0]             loop4_sp_o,
    output logic [15:0]             loop5_target_o,
    output logic [EVENT_W-1:0]      event_o,
    output logic                    audible_o,
    output logic                    shutdown_o,
    output logic                    irq_o
);

    if (EVENT_W < 1 || EVENT_W > larb_pkg::EVENT_W_MAX) begin : g_bad_width
        $error("EVENT_W must lie between 1 and 15");
    end

    logic [15:0]              upper_lim;
    logic [15:0]              lower_lim;
    logic [15:0]              alarm_type;
    logic [15:0]              alarm_mode;
    logic [15:0]              out_sel;
    logic [15:0]              high_thr;
    logic [15:0]              low_thr;
    logic [15:0]              hysteresis;
    logic [15:0]              target;
    logic [larb_pkg::IRQ_W-1:0] irq_stat;
    logic [larb_pkg::IRQ_W-1:0] irq_mask;
    logic [larb_pkg::IRQ_W-1:0] irq_set;
    logic [15:0]              next_rdata;
    logic [15:0]              pct_view;
    logic                     ok_write;
    logic                     ro_write;
    logic                     reject;
    logic                     silence_s;
    logic                     silence_d;
    logic                     ack;
    logic                     alarm_active;
    logic                     alarm_rise;

    // Pin path: the silence button is asynchronous to clk_i.
    larb_sync #(
        .RST_VAL (1'b1)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (silence_n_i),
        .q_o   (silence_s)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) silence_d <= 1'b1;
        else       silence_d <= silence_s;
    end

    // A latched alarm is acknowledged by the control register or the button.
    assign ack = (wr_i && addr_i == larb_pkg::A_CTRL && wdata_i[larb_pkg::CTRL_ACK])
               || (silence_d && !silence_s);

    // Range check per register; a refused write keeps the old contents.
    always_comb begin
        ok_write = 1'b1;
        case (addr_i)
            larb_pkg::A_UPPER:  ok_write = $signed(wdata_i) >= $signed(lower_lim);
            larb_pkg::A_LOWER:  ok_write = $signed(wdata_i) <= $signed(upper_lim);
            larb_pkg::A_TYPE:   ok_write = wdata_i <= larb_pkg::TYPE_MAX;
            larb_pkg::A_OUTSEL: ok_write = ((wdata_i & (wdata_i - 16'h0001)) == 16'h0000)
                                           && (wdata_i[15:EVENT_W] == '0);
            larb_pkg::A_HYST:   ok_write = !wdata_i[15];
            default:            ok_write = 1'b1;
        endcase
    end

    assign ro_write = wr_i && (addr_i == larb_pkg::A_MEAS || addr_i == larb_pkg::A_PCT);
    assign reject   = (wr_i && !ok_write) || ro_write;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            upper_lim  <= larb_pkg::RST_UPPER;
            lower_lim  <= larb_pkg::RST_LOWER;
            alarm_type <= larb_pkg::RST_ZERO;
            alarm_mode <= larb_pkg::RST_ZERO;
            out_sel    <= larb_pkg::RST_ZERO;
            high_thr   <= larb_pkg::RST_UPPER;
            low_thr    <= larb_pkg::RST_LOWER;
            hysteresis <= larb_pkg::RST_ZERO;
            target     <= larb_pkg::RST_ZERO;
        end else if (wr_i && ok_write) begin
            case (addr_i)
                larb_pkg::A_UPPER:  upper_lim  <= wdata_i;
                larb_pkg::A_LOWER:  lower_lim  <= wdata_i;
                larb_pkg::A_TYPE:   alarm_type <= wdata_i;
                larb_pkg::A_MODE:   alarm_mode <= wdata_i;
                larb_pkg::A_OUTSEL: out_sel    <= wdata_i;
                larb_pkg::A_HIGH:   high_thr   <= wdata_i;
                larb_pkg::A_LOW:    low_thr    <= wdata_i;
                larb_pkg::A_HYST:   hysteresis <= wdata_i;
                larb_pkg::A_TARGET: target     <= wdata_i;
                default:            target     <= target;
            endcase
        end
    end

    // Setpoint requests for loop four are clamped between the two limits.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            loop4_sp_o <= larb_pkg::RST_ZERO;
        end else if ($signed(loop4_sp_i) > $signed(upper_lim)) begin
            loop4_sp_o <= upper_lim;
        end else if ($signed(loop4_sp_i) < $signed(lower_lim)) begin
            loop4_sp_o <= lower_lim;
        end else begin
            loop4_sp_o <= loop4_sp_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) loop5_target_o <= larb_pkg::RST_ZERO;
        else       loop5_target_o <= target;
    end

    larb_alarm u_alarm (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .pv_i     (loop4_pv_i),
        .sp_i     (loop4_sp_o),
        .type_i   (alarm_type[2:0]),
        .hi_i     (high_thr),
        .lo_i     (low_thr),
        .hys_i    (hysteresis),
        .latch_i  (alarm_mode[larb_pkg::MODE_LATCH]),
        .ack_i    (ack),
        .active_o (alarm_active),
        .rise_o   (alarm_rise)
    );

    // Only mode bits one, two, five and six are ever looked at.
    for (genvar i = 0; i < EVENT_W; i++) begin : g_event
        always_ff @(posedge clk_i) begin
            if (rst_i) event_o[i] <= 1'b0;
            else       event_o[i] <= out_sel[i] & (alarm_active ^ alarm_mode[larb_pkg::MODE_POL]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            audible_o  <= 1'b0;
            shutdown_o <= 1'b0;
        end else begin
            audible_o  <= alarm_active & alarm_mode[larb_pkg::MODE_AUDIBLE];
            shutdown_o <= alarm_active & alarm_mode[larb_pkg::MODE_SHUTDOWN];
        end
    end

    // Interrupt status: set wins over a write-one-to-clear in the same cycle.
    always_comb begin
        irq_set = '0;
        irq_set[larb_pkg::IRQ_ALARM]  = alarm_rise;
        irq_set[larb_pkg::IRQ_REJECT] = reject;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= '0;
        end else if (wr_i && addr_i == larb_pkg::A_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~wdata_i[larb_pkg::IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat <= irq_stat | irq_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)                                       irq_mask <= '0;
        else if (wr_i && addr_i == larb_pkg::A_IRQ_MASK) irq_mask <= wdata_i[larb_pkg::IRQ_W-1:0];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) irq_o <= 1'b0;
        else       irq_o <= |(irq_stat & irq_mask);
    end

    // The output percentage is saturated so software never sees a value
    // outside the documented span even if the control loop overshoots.
    always_comb begin
        if ($signed(loop5_out_i) > $signed(larb_pkg::PCT_MAX))      pct_view = larb_pkg::PCT_MAX;
        else if ($signed(loop5_out_i) < $signed(larb_pkg::PCT_MIN)) pct_view = larb_pkg::PCT_MIN;
        else                                                         pct_view = loop5_out_i;
    end

    always_comb begin
        next_rdata = larb_pkg::RST_ZERO;
        case (addr_i)
            larb_pkg::A_UPPER:    next_rdata = upper_lim;
            larb_pkg::A_LOWER:    next_rdata = lower_lim;
            larb_pkg::A_TYPE:     next_rdata = alarm_type;
            larb_pkg::A_MODE:     next_rdata = alarm_mode;
            larb_pkg::A_OUTSEL:   next_rdata = out_sel;
            larb_pkg::A_HIGH:     next_rdata = high_thr;
            larb_pkg::A_LOW:      next_rdata = low_thr;
            larb_pkg::A_HYST:     next_rdata = hysteresis;
            larb_pkg::A_TARGET:   next_rdata = target;
            larb_pkg::A_MEAS:     next_rdata = loop5_pv_i;
            larb_pkg::A_PCT:      next_rdata = pct_view;
            larb_pkg::A_IRQ_STAT: next_rdata = 16'(irq_stat);
            larb_pkg::A_IRQ_MASK: next_rdata = 16'(irq_mask);
            larb_pkg::A_CTRL:     next_rdata = {15'h0000, alarm_active};
            default:              next_rdata = larb_pkg::RST_ZERO;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)     rdata_o <= larb_pkg::RST_ZERO;
        else if (rd_i) rdata_o <= next_rdata;
        else           rdata_o <= larb_pkg::RST_ZERO;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_ro_write;
        wr_i && (addr_i == larb_pkg::A_MEAS || addr_i == larb_pkg::A_PCT);
    endsequence

    sequence s_read_upper;
        rd_i && addr_i == larb_pkg::A_UPPER;
    endsequence

    a_upper_store: assert property (
        wr_i && addr_i == larb_pkg::A_UPPER && $signed(wdata_i) >= $signed(lower_lim)
        |=> upper_lim == $past(wdata_i))
        else $error("upper limit write not stored");

    a_upper_read: assert property (
        s_read_upper |=> rdata_o == $past(upper_lim))
        else $error("upper limit read mismatch");

    a_lower_bound: assert property (
        wr_i && addr_i == larb_pkg::A_LOWER && $signed(wdata_i) > $signed(upper_lim)
        |=> $stable(lower_lim))
        else $error("lower limit above upper accepted");

    a_type_range: assert property (
        wr_i && addr_i == larb_pkg::A_TYPE && wdata_i > larb_pkg::TYPE_MAX |=> $stable(alarm_type))
        else $error("bad alarm type accepted");

    a_hyst_sign: assert property (
        wr_i && addr_i == larb_pkg::A_HYST && wdata_i[15] |=> $stable(hysteresis) && !hysteresis[15])
        else $error("negative hysteresis accepted");

    a_ro_flag: assert property (
        s_ro_write |=> irq_stat[larb_pkg::IRQ_REJECT])
        else $error("read-only write not flagged");

    a_pct_span: assert property (
        rd_i && addr_i == larb_pkg::A_PCT
        |=> $signed(rdata_o) <= $signed(larb_pkg::PCT_MAX) && $signed(rdata_o) >= $signed(larb_pkg::PCT_MIN))
        else $error("output percentage out of span");

    a_audible_gate: assert property (
        !alarm_mode[larb_pkg::MODE_AUDIBLE] && $stable(alarm_mode) |=> !audible_o)
        else $error("audible raised with bit five clear");

    a_shutdown_gate: assert property (
        alarm_active && alarm_mode[larb_pkg::MODE_SHUTDOWN] |=> shutdown_o)
        else $error("shutdown missed on alarm");

    a_event_idle: assert property (
        !alarm_active && !alarm_mode[larb_pkg::MODE_POL] |=> event_o == '0)
        else $error("event output closed without alarm");

endmodule

// *** larb_host.sv ***
/*
 * Host model: the computer that reads and writes the bank's registers.
 * Assumes clk_i is the bank clock and read data stand one cycle after the strobe.
 */
`timescale 1ns/1ps
module larb_host (
    input  wire logic        clk_i,
    output logic      [15:0] addr_o,
    output logic      [15:0] wdata_o,
    output logic             wr_o,
    output logic             rd_o,
    input  wire logic [15:0] rdata_i
);
    initial begin
        addr_o = 16'h0000;
        wdata_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // Registers hold tenths, so an engineering value is multiplied by ten.
    function automatic logic [15:0] scale(input int eng);
        return 16'(eng * 10);
    endfunction

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        // Released lines show junk so that a late sample cannot match by luck.
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask
endmodule

// *** larb_bench.sv ***
/*
 * Self-checking bench: larb_top against a register model kept here.
 * Assumes larb_host speaks the register port; the bench drives the silence pin.
 */
`timescale 1ns/1ps
module larb_bench;
    localparam int EW = 15;
    logic          clk_i = 1'b0;
    logic          rst_i = 1'b1;
    logic [15:0]   addr, wdata, rdata, sp4_o, tgt_o, v;
    logic [15:0]   pv4 = 16'h0000, sp4 = 16'h0000, pv5 = 16'h0000, out5 = 16'h0000;
    logic          wr, rd, aud, shut, irq;
    logic          btn_n = 1'b1;
    logic [EW-1:0] ev;
    logic [15:0]   m [int];
    int            n_fail = 0;
    int            cmp_count = 0;

    initial forever #25 clk_i = ~clk_i;

    larb_host host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
    larb_top #(.EVENT_W(EW)) DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .loop4_pv_i(pv4), .loop4_sp_i(sp4), .loop5_pv_i(pv5), .loop5_out_i(out5),
        .silence_n_i(btn_n), .rdata_o(rdata), .loop4_sp_o(sp4_o), .loop5_target_o(tgt_o), .event_o(ev),
        .audible_o(aud), .shutdown_o(shut), .irq_o(irq));

    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    function automatic logic [15:0] rv(input logic [15:0] a);
        if (a == 16'h006D) return pv5;
        if (a == 16'h006E) begin
            if ($signed(out5) > $signed(16'h2710)) return 16'h2710;
            if ($signed(out5) < $signed(16'hD8F0)) return 16'hD8F0;
            return out5;
        end
        return m.exists(a) ? m[a] : 16'h0000;
    endfunction

    task automatic rc(input logic [15:0] a);
        host.rd(a, v);
        chk($sformatf("reg %h", a), v, rv(a));
    endtask

    task automatic mw(input logic [15:0] a, input logic [15:0] d);
        bit ok;
        ok = 1'b1;
        case (a)
            16'h0064: ok = $signed(d) >= $signed(m[16'h0065]);
            16'h0065: ok = $signed(d) <= $signed(m[16'h0064]);
            16'h0066: ok = d <= 16'h0006;
            16'h0068: ok = (d & (d - 16'h0001)) == 16'h0000 && d < (16'h0001 << EW);
            16'h006B: ok = !d[15];
            16'h006D, 16'h006E: ok = 1'b0;
            16'h0080: m[16'h0080] = m[16'h0080] & ~d;
            16'h0081: d = d & 16'h0003;
            default: ;
        endcase
        if (!ok) m[16'h0080] = m[16'h0080] | 16'h0002;
        else if (m.exists(a) && a != 16'h0080) m[a] = d;
        host.wr(a, d);
    endtask

    // Pulse latency from input to outputs is three edges; five leaves margin.
    task automatic step(input logic [15:0] p, input logic a_e, input logic s_e, input logic [15:0] e_e);
        pv4 <= p;
        repeat (5) @(posedge clk_i);
        #1;
        chk("audible", 16'(aud), 16'(a_e));
        chk("shutdown", 16'(shut), 16'(s_e));
        chk("event", 16'(ev), e_e);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        logic [15:0] a;
        logic [15:0] outs [4];
        int i;
        outs = '{16'h4E20, 16'hB1E0, 16'h04D2, 16'h2710};
        i = $urandom(98260);
        for (i = 16'h64; i <= 16'h6C; i++) m[i] = 16'h0000;
        m[16'h0064] = 16'h7FFF;
        m[16'h0069] = 16'h7FFF;
        m[16'h0065] = 16'h8000;
        m[16'h006A] = 16'h8000;
        m[16'h0080] = 16'h0000;
        m[16'h0081] = 16'h0000;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 16'h64; i <= 16'h6E; i++) rc(16'(i));
        rc(16'h0090);
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            mw(16'h0066, 16'(i));
            rc(16'h0066);
        end
        mw(16'h0066, 16'h0000);
        $display("test type done");
        // The type register is left off here so that random thresholds raise no alarm.
        for (i = 0; i < 40; i++) begin
            a = 16'h0064 + 16'($urandom_range(8));
            a = (a == 16'h0066) ? 16'h0067 : a;
            mw(a, 16'($urandom));
            rc(a);
            chk("target", tgt_o, m[16'h006C]);
        end
        $display("test random done");
        for (i = 0; i <= EW; i++) begin
            mw(16'h0068, 16'h0001 << i);
            rc(16'h0068);
            chk("event", 16'(ev), m[16'h0067][2] ? m[16'h0068] : 16'h0000);
        end
        mw(16'h0068, 16'h0003);
        rc(16'h0068);
        $display("test outsel done");
        pv5 <= 16'($urandom);
        for (i = 0; i < 4; i++) begin
            out5 <= outs[i];
            mw(16'h006E, 16'h1111);
            rc(16'h006E);
        end
        mw(16'h006D, 16'h2222);
        rc(16'h006D);
        rc(16'h0080);
        $display("test readonly done");
        mw(16'h0065, 16'h8000);
        mw(16'h0064, host.scale(100));
        mw(16'h0065, 16'h0400);
        rc(16'h0065);
        mw(16'h006B, 16'h8000);
        rc(16'h006B);
        sp4 <= 16'h7000;
        mw(16'h0069, host.scale(10));
        mw(16'h006B, host.scale(1));
        mw(16'h0068, 16'h0004);
        mw(16'h0067, 16'h0069);
        mw(16'h0080, 16'h0003);
        mw(16'h0081, 16'h0001);
        mw(16'h0066, 16'h0001);
        chk("setpoint", sp4_o, 16'h03E8);
        // A request below the raised lower limit must come out at that limit.
        sp4 <= 16'h8000;
        mw(16'h0065, 16'hFF9C);
        @(posedge clk_i);
        #1;
        chk("setpoint", sp4_o, 16'hFF9C);
        step(16'h00C8, 1'b1, 1'b1, 16'h0004);
        m[16'h0080] = m[16'h0080] | 16'h0001;
        chk("irq", 16'(irq), 16'h0001);
        step(16'h005F, 1'b1, 1'b1, 16'h0004);
        step(16'h0032, 1'b0, 1'b0, 16'h0000);
        mw(16'h0067, 16'h0026);
        step(16'h00C8, 1'b1, 1'b0, 16'h0000);
        step(16'h0032, 1'b1, 1'b0, 16'h0000);
        mw(16'h0082, 16'h0001);
        step(16'h0032, 1'b0, 1'b0, 16'h0004);
        step(16'h00C8, 1'b1, 1'b0, 16'h0000);
        step(16'h0032, 1'b1, 1'b0, 16'h0000);
        // The button acknowledges the held alarm on its falling edge only.
        btn_n <= 1'b0;
        step(16'h0032, 1'b0, 1'b0, 16'h0004);
        btn_n <= 1'b1;
        // Deviation high measures from the clamped setpoint, here minus ten units.
        mw(16'h0067, 16'h0020);
        mw(16'h0066, 16'h0004);
        step(16'h0032, 1'b1, 1'b0, 16'h0004);
        step(16'hFF38, 1'b0, 1'b0, 16'h0000);
        mw(16'h006A, host.scale(-10));
        mw(16'h0066, 16'h0002);
        step(16'hFF38, 1'b1, 1'b0, 16'h0004);
        step(16'h0032, 1'b0, 1'b0, 16'h0000);
        mw(16'h0080, 16'h0003);
        rc(16'h0080);
        chk("irq", 16'(irq), 16'h0000);
        $display("test alarm done");
        tally_and_finish();
    end
endmodule
